// ### core/kps_regs.svh
// register map, field positions, reset values and timing for the keypad scanner
`ifndef KPS_REGS_SVH
`define KPS_REGS_SVH

// register offsets
`define KPS_ADDR_COL        8'hd1
`define KPS_ADDR_ROW        8'hd2
`define KPS_ADDR_TIMING     8'hd3
`define KPS_ADDR_STATUS     8'hd4
`define KPS_ADDR_ORDER_LO   8'hd5
`define KPS_ADDR_ORDER_HI   8'hd6
`define KPS_ADDR_DIM        8'hd7

// reset values
`define KPS_RST_COL         8'h1f
`define KPS_RST_ROW         8'h3f
`define KPS_RST_TIMING      8'h00
`define KPS_RST_STATUS      8'h00
`define KPS_RST_ORDER_LO    8'h88
`define KPS_RST_ORDER_HI    8'h46
`define KPS_RST_DIM         8'h65

// status register bits
`define KPS_STAT_IRQ_EN     0
`define KPS_STAT_DETECT     1
`define KPS_STAT_SCAN_EN    2
`define KPS_STAT_BUSY       3

// timing field positions
`define KPS_DEB_LSB         2
`define KPS_SCAN_LSB        0

// timing in the 1 kHz tick domain
`define KPS_TICK_US         1000
`define KPS_DEB_STEP_MS     4
`define KPS_DEB_STEPS_MAX   64
`define KPS_SCAN_MS_MAX     4

`endif

// ### core/kps_pkg.sv
// types shared by the keypad scanner
package kps_pkg;

	// register bus request travelling as one bundle
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} kps_bus_req_t;

	// scan sequencer states
	typedef enum logic [2:0] {
		KPS_IDLE  = 3'b000,
		KPS_PDEB  = 3'b001,
		KPS_SCAN  = 3'b010,
		KPS_RWAIT = 3'b011,
		KPS_RDEB  = 3'b100
	} kps_state_t;

endpackage

// ### core/kps_scanner.sv
// keypad matrix scanner with debounce, programmable order and bypass mode
`include "kps_regs.svh"

module kps_scanner #(
	parameter int NCOL = 5,
	parameter int NROW = 6
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// register port
	input  wire kps_pkg::kps_bus_req_t bus_req,
	output logic [7:0]                rdata,
	// timing source and gate from clock control
	input  wire logic                 tick_1khz,
	input  wire logic                 keypad_clock_enable,
	// keypad matrix
	input  wire logic [NROW-1:0]      row_in,
	output logic [NCOL-1:0]           col_out,
	// keypad interrupt
	output logic                      key_irq
);

	// registers
	logic [7:0]          key_column_drive_r;
	logic [7:0]          key_row_sense_r;
	logic [7:0]          scan_timing_reg_r;
	logic [7:0]          scan_order_low_r;
	logic [7:0]          scan_order_high_r;
	logic [7:0]          keypad_dimension_reg_r;
	logic                irq_en_r;
	logic                detect_r;
	logic                hw_scan_enable_r;
	logic [NROW-1:0]     row_meta_r;
	logic [NROW-1:0]     row_sync_r;
	logic [1:0]          settle_r;
	kps_pkg::kps_state_t state_r;
	kps_pkg::kps_state_t state_nxt;
	logic [2:0]          slot_r;
	logic [2:0]          slot_nxt;
	logic [2:0]          row_idx_r;
	logic [2:0]          row_idx_nxt;
	logic [8:0]          wait_r;
	logic [8:0]          wait_nxt;
	logic [1:0]          hits_r;
	logic [1:0]          hits_nxt;
	logic [2:0]          hit_col_r;
	logic [2:0]          hit_col_nxt;
	logic [2:0]          hit_row_r;
	logic [2:0]          hit_row_nxt;
	logic                found;
	logic [NCOL-1:0]     col_nxt;
	logic [7:0]          rdata_nxt;

	// bus decode
	wire wr_col    = bus_req.wr && bus_req.addr == `KPS_ADDR_COL;
	wire wr_timing = bus_req.wr && bus_req.addr == `KPS_ADDR_TIMING;
	wire wr_status = bus_req.wr && bus_req.addr == `KPS_ADDR_STATUS;
	wire wr_ord_lo = bus_req.wr && bus_req.addr == `KPS_ADDR_ORDER_LO;
	wire wr_ord_hi = bus_req.wr && bus_req.addr == `KPS_ADDR_ORDER_HI;
	wire wr_dim    = bus_req.wr && bus_req.addr == `KPS_ADDR_DIM;

	// keypad size, out-of-range values fall back to the full matrix
	wire [2:0] dim_cols = keypad_dimension_reg_r[2:0];
	wire [2:0] dim_rows = keypad_dimension_reg_r[6:4];
	wire [2:0] ncols    = (dim_cols == 3'h0 || dim_cols > 3'(NCOL)) ?
	                      3'(NCOL) : dim_cols;
	wire [2:0] nrows    = (dim_rows == 3'h0 || dim_rows > 3'(NROW)) ?
	                      3'(NROW) : dim_rows;

	// masks of the columns and rows that belong to the keypad
	wire [NCOL-1:0] col_mask = NCOL'((8'h01 << ncols) - 8'h01);
	wire [NROW-1:0] row_mask = NROW'((8'h01 << nrows) - 8'h01);
	wire            any_low  = |(~row_sync_r & row_mask);

	// debounce length in ticks: zero in the field means the longest
	wire [5:0] deb_field = scan_timing_reg_r[`KPS_DEB_LSB +: 6];
	wire [6:0] deb_steps = (deb_field == 6'h00) ?
	                       7'(`KPS_DEB_STEPS_MAX) : {1'b0, deb_field};
	wire [8:0] deb_ticks = 9'(deb_steps * `KPS_DEB_STEP_MS * 1000 /
	                       `KPS_TICK_US);

	// check interval in ticks, same for every column order
	wire [1:0] scan_field = scan_timing_reg_r[`KPS_SCAN_LSB +: 2];
	wire [8:0] scan_ticks = (scan_field == 2'h0) ?
	                        9'(`KPS_SCAN_MS_MAX * 1000 / `KPS_TICK_US) :
	                        9'(scan_field * 1000 / `KPS_TICK_US);

	// column picked by the current order slot
	wire [14:0] order   = {scan_order_high_r[6:0], scan_order_low_r};
	wire [2:0]  cur_col = order[3*slot_r +: 3];
	wire        row_hit = ~row_sync_r[row_idx_r];
	wire        last_row = row_idx_r == nrows - 3'h1;
	wire        last_col = slot_r == ncols - 3'h1;
	wire        timing_on = keypad_clock_enable && tick_1khz;
	wire        wait_done = timing_on && wait_r == 9'h001;

	// one-low column pattern; an order entry past the matrix drives none
	wire [NCOL-1:0] scan_cols = ~(NCOL'(8'h01 << cur_col) & col_mask);

	// synced rows match the all-low pattern two edges after it is driven
	wire rows_valid = settle_r[1];

	// row synchroniser, first stage only feeds the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			row_meta_r <= '1;
			row_sync_r <= '1;
		end else begin
			row_meta_r <= row_in;
			row_sync_r <= row_meta_r;
		end
	end

	// a stale scan pattern must not pass for a release, or the
	// release debounce would run short
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_r <= 2'h0;
		end else begin
			settle_r <= {settle_r[0], col_out == ~col_mask};
		end
	end

	// sequencer next state; ticks only count while the keypad clock runs
	always_comb begin
		state_nxt   = state_r;
		slot_nxt    = slot_r;
		row_idx_nxt = row_idx_r;
		wait_nxt    = wait_r;
		hits_nxt    = hits_r;
		hit_col_nxt = hit_col_r;
		hit_row_nxt = hit_row_r;
		found       = 1'b0;
		if (timing_on && wait_r != 9'h000) begin
			wait_nxt = wait_r - 9'h001;
		end
		case (state_r)
			kps_pkg::KPS_IDLE: begin
				if (keypad_clock_enable && rows_valid && any_low) begin
					state_nxt = kps_pkg::KPS_PDEB;
					wait_nxt  = deb_ticks;
				end
			end
			kps_pkg::KPS_PDEB: begin
				if (wait_done) begin
					if (any_low) begin
						state_nxt   = kps_pkg::KPS_SCAN;
						slot_nxt    = 3'h0;
						row_idx_nxt = 3'h0;
						hits_nxt    = 2'h0;
						wait_nxt    = scan_ticks;
					end else begin
						state_nxt = kps_pkg::KPS_IDLE;
					end
				end
			end
			kps_pkg::KPS_SCAN: begin
				if (wait_done) begin
					wait_nxt = scan_ticks;
					if (row_hit) begin
						hit_col_nxt = cur_col;
						hit_row_nxt = row_idx_r;
						if (hits_r != 2'h2) begin
							hits_nxt = hits_r + 2'h1;
						end
					end
					if (!last_row) begin
						row_idx_nxt = row_idx_r + 3'h1;
					end else begin
						row_idx_nxt = 3'h0;
						slot_nxt    = slot_r + 3'h1;
						if (last_col) begin
							state_nxt = kps_pkg::KPS_RWAIT;
							found     = hits_nxt == 2'h1;
						end
					end
				end
			end
			kps_pkg::KPS_RWAIT: begin
				if (keypad_clock_enable && rows_valid && !any_low) begin
					state_nxt = kps_pkg::KPS_RDEB;
					wait_nxt  = deb_ticks;
				end
			end
			kps_pkg::KPS_RDEB: begin
				if (wait_done) begin
					if (any_low) begin
						wait_nxt = deb_ticks;
					end else begin
						state_nxt = kps_pkg::KPS_IDLE;
					end
				end
			end
			default: begin
				state_nxt = kps_pkg::KPS_IDLE;
			end
		endcase
		if (!hw_scan_enable_r) begin
			state_nxt = kps_pkg::KPS_IDLE;
			found     = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r   <= kps_pkg::KPS_IDLE;
			slot_r    <= 3'h0;
			row_idx_r <= 3'h0;
			wait_r    <= 9'h000;
			hits_r    <= 2'h0;
			hit_col_r <= 3'h0;
			hit_row_r <= 3'h0;
		end else begin
			state_r   <= state_nxt;
			slot_r    <= slot_nxt;
			row_idx_r <= row_idx_nxt;
			wait_r    <= wait_nxt;
			hits_r    <= hits_nxt;
			hit_col_r <= hit_col_nxt;
			hit_row_r <= hit_row_nxt;
		end
	end

	// column pins: scan pattern, all keypad columns low, or bypass value
	always_comb begin
		if (!hw_scan_enable_r) begin
			col_nxt = key_column_drive_r[NCOL-1:0];
		end else if (state_r == kps_pkg::KPS_SCAN) begin
			col_nxt = scan_cols;
		end else begin
			col_nxt = ~col_mask;
		end
	end

	// column pins from a flop so they never glitch between patterns
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			col_out <= NCOL'(`KPS_RST_COL);
		end else begin
			col_out <= col_nxt;
		end
	end

	// column register: firmware value, replaced only by a valid key
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_column_drive_r <= `KPS_RST_COL;
		end else if (found) begin
			key_column_drive_r <= {3'h0, ~(NCOL'(8'h01 << hit_col_nxt))};
		end else if (wr_col) begin
			key_column_drive_r <= {3'h0, bus_req.wdata[4:0]};
		end
	end

	// row register: latched key row when scanning, live rows in bypass
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_row_sense_r <= `KPS_RST_ROW;
		end else if (found) begin
			key_row_sense_r <= {2'h0, ~(NROW'(8'h01 << hit_row_nxt))};
		end else if (!hw_scan_enable_r) begin
			key_row_sense_r <= {2'h0, row_sync_r};
		end
	end

	// timing, order and size registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scan_timing_reg_r      <= `KPS_RST_TIMING;
			scan_order_low_r       <= `KPS_RST_ORDER_LO;
			scan_order_high_r      <= `KPS_RST_ORDER_HI;
			keypad_dimension_reg_r <= `KPS_RST_DIM;
		end else begin
			if (wr_timing) scan_timing_reg_r <= bus_req.wdata;
			if (wr_ord_lo) scan_order_low_r <= bus_req.wdata;
			if (wr_ord_hi) scan_order_high_r <= {1'b0, bus_req.wdata[6:0]};
			if (wr_dim) keypad_dimension_reg_r <= bus_req.wdata & 8'h77;
		end
	end

	// control and detect flag; a new key beats a same-cycle clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_r         <= 1'b0;
			hw_scan_enable_r <= 1'b0;
			detect_r         <= 1'b0;
		end else begin
			if (wr_status) begin
				irq_en_r         <= bus_req.wdata[`KPS_STAT_IRQ_EN];
				hw_scan_enable_r <= bus_req.wdata[`KPS_STAT_SCAN_EN];
			end
			if (found) begin
				detect_r <= 1'b1;
			end else if (wr_status && bus_req.wdata[`KPS_STAT_DETECT]) begin
				detect_r <= 1'b0;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (bus_req.addr)
			`KPS_ADDR_COL:      rdata_nxt = key_column_drive_r;
			`KPS_ADDR_ROW:      rdata_nxt = key_row_sense_r;
			`KPS_ADDR_TIMING:   rdata_nxt = scan_timing_reg_r;
			`KPS_ADDR_STATUS:   rdata_nxt = {4'h0,
			                    state_r != kps_pkg::KPS_IDLE,
			                    hw_scan_enable_r, detect_r, irq_en_r};
			`KPS_ADDR_ORDER_LO: rdata_nxt = scan_order_low_r;
			`KPS_ADDR_ORDER_HI: rdata_nxt = scan_order_high_r;
			`KPS_ADDR_DIM:      rdata_nxt = keypad_dimension_reg_r;
			default:            rdata_nxt = 8'h00;
		endcase
	end

	// read data and interrupt, both from flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata   <= 8'h00;
			key_irq <= 1'b0;
		end else begin
			rdata   <= bus_req.rd ? rdata_nxt : 8'h00;
			key_irq <= detect_r && irq_en_r;
		end
	end

endmodule // kps_scanner

// ### tb/kps_scanner_props.sv
// port assertions for the keypad scanner
module kps_scanner_props (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// register port
	input wire kps_pkg::kps_bus_req_t bus_req,
	input wire logic [7:0]            rdata,
	// timing source and gate
	input wire logic                  tick_1khz,
	input wire logic                  keypad_clock_enable,
	// keypad matrix and interrupt
	input wire logic [5:0]            row_in,
	input wire logic [4:0]            col_out,
	input wire logic                  key_irq
);
	logic       scan_en_r;
	logic       irq_en_r;
	logic       col_wr_r;
	logic       seen_en_r;
	logic [4:0] col_val_r;
	wire        stat_wr = bus_req.wr && bus_req.addr == 8'hd4;
	wire        col_wr  = bus_req.wr && bus_req.addr == 8'hd1;

	// shadow enables, known only from bus writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scan_en_r <= 1'b0;
			irq_en_r  <= 1'b0;
			col_wr_r  <= 1'b0;
			col_val_r <= 5'h1f;
			seen_en_r <= 1'b0;
		end else begin
			if (stat_wr && bus_req.wdata[2]) seen_en_r <= 1'b1;
			if (stat_wr) scan_en_r <= bus_req.wdata[2];
			if (stat_wr) irq_en_r <= bus_req.wdata[0];
			if (col_wr) col_wr_r <= 1'b1;
			if (col_wr) col_val_r <= bus_req.wdata[4:0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_col_wr;
		!scan_en_r && col_wr ##1 !bus_req.wr;
	endsequence
	// guard on one-hot: only scan patterns are checked; idle checks stop when gated too
	sequence s_frozen;
		(scan_en_r && !keypad_clock_enable && !stat_wr) [*4];
	endsequence

	property p_rdata_quiet;
		!$past(bus_req.rd) |-> rdata == 8'h00;
	endproperty
	property p_bypass_col;
		s_col_wr ##1 !scan_en_r |-> col_out == col_val_r;
	endproperty
	property p_reset_off;
		!scan_en_r && !col_wr_r && !seen_en_r |-> col_out == 5'h1f;
	endproperty
	property p_one_col;
		scan_en_r && $past(scan_en_r, 2) |-> col_out == 5'h00 || $onehot(~col_out);
	endproperty
	property p_gate;
		s_frozen ##0 $onehot(~col_out) |-> $stable(col_out) && !$rose(key_irq);
	endproperty
	property p_irq_cause;
		$rose(key_irq) |-> irq_en_r && scan_en_r;
	endproperty
	property p_irq_off;
		!irq_en_r && !$past(irq_en_r) |-> !key_irq;
	endproperty
	property p_irq_clear;
		stat_wr && bus_req.wdata[1] |-> ##2 !key_irq;
	endproperty

	a_rdata_quiet: assert property (p_rdata_quiet)
		else $error("read data not zero outside read slot");
	a_bypass_col: assert property (p_bypass_col)
		else $error("columns do not follow column register");
	a_reset_off: assert property (p_reset_off)
		else $error("columns moved before scan enable");
	a_one_col: assert property (p_one_col)
		else $error("more than one column low while scanning");
	a_gate: assert property (p_gate)
		else $error("scan moved while keypad clock gated");
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without enables");
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt high while masked");
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt survived detect clear");
endmodule // kps_scanner_props

bind kps_scanner kps_scanner_props u_props (.clk(clk), .rst(rst),
	.bus_req(bus_req), .rdata(rdata), .tick_1khz(tick_1khz),
	.keypad_clock_enable(keypad_clock_enable), .row_in(row_in),
	.col_out(col_out), .key_irq(key_irq));

// ### tb/kps_keypad.sv
// switch matrix model: a closed key pulls its row low when its column is low
module kps_keypad (
	// column drives from the scanner
	input  wire logic [4:0]  col_out,
	// closed switches, bit col*6+row
	input  wire logic [29:0] press,
	// row sense lines
	output logic      [5:0]  row_in
);
	// pull-ups hold released rows high, never a stale level
	always_comb begin
		row_in = 6'h3f;
		for (int c = 0; c < 5; c++)
			for (int r = 0; r < 6; r++)
				if (press[c*6+r] && !col_out[c]) row_in[r] = 1'b0;
	end
endmodule // kps_keypad

// ### tb/kps_scanner_tb.sv
// self-checking bench for the keypad scanner
module kps_scanner_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic       w;
		logic [7:0] e;
	} kps_row_t;
	logic                  clk, rst, tick_1khz, keypad_clock_enable, key_irq;
	kps_pkg::kps_bus_req_t bus_req;
	logic [7:0]            rdata;
	logic [5:0]            row_in;
	logic [4:0]            col_out;
	logic [29:0]           press;
	logic [1:0]            tdiv;
	int                    mismatches, checks, i;
	kps_row_t              rows [16];

	kps_keypad u_pad (.col_out(col_out), .press(press), .row_in(row_in));
	kps_scanner dut (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
		.tick_1khz(tick_1khz), .keypad_clock_enable(keypad_clock_enable),
		.row_in(row_in), .col_out(col_out), .key_irq(key_irq));

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = rdata;
	endtask
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] g;
		rd_reg(a, g);
		check(n, e, g);
	endtask
	task automatic set_press(input logic [29:0] p);
		@(posedge clk);
		press <= p;
	endtask
	// polls the busy bit, bounded
	task automatic wait_idle();
		logic [7:0] s;
		for (int k = 0; k < 300; k++) begin
			rd_reg(8'hd4, s);
			if (s[3] === 1'b0) break;
		end
		check("busy", 8'h00, {7'h00, s[3]});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// tick every 4 cycles: a real 1 ms tick would make the run far too long
	always @(posedge clk) begin
		if (rst) begin
			tdiv      <= 2'h0;
			tick_1khz <= 1'b0;
		end else begin
			tdiv      <= tdiv + 2'h1;
			tick_1khz <= (tdiv == 2'h3);
		end
	end
	// tests need about 3000 cycles; give up after 10000
	initial begin
		#200000;
		mismatches++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		bus_req = '0;
		keypad_clock_enable = 1'b1;
		press = '0;
		rows = '{'{8'hd1, 8'h00, 1'b0, 8'h1f}, '{8'hd2, 8'h00, 1'b0, 8'h3f},
			'{8'hd3, 8'h00, 1'b0, 8'h00}, '{8'hd4, 8'h00, 1'b0, 8'h00},
			'{8'hd5, 8'h00, 1'b0, 8'h88}, '{8'hd6, 8'h00, 1'b0, 8'h46},
			'{8'hd7, 8'h00, 1'b0, 8'h65}, '{8'hd0, 8'h00, 1'b0, 8'h00},
			'{8'hd2, 8'h00, 1'b1, 8'h3f}, '{8'hd0, 8'h5a, 1'b1, 8'h00},
			'{8'hd1, 8'h1e, 1'b1, 8'h1e}, '{8'hd1, 8'h0f, 1'b1, 8'h0f},
			'{8'hd1, 8'h1f, 1'b1, 8'h1f}, '{8'hd7, 8'hff, 1'b1, 8'h77},
			'{8'hd7, 8'h65, 1'b1, 8'h65}, '{8'hd3, 8'h05, 1'b1, 8'h05}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 16; i++) begin
			if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
			rd_chk("register", rows[i].a, rows[i].e);
			if (rows[i].w && rows[i].a == 8'hd1)
				check("col_out", rows[i].e, {3'h0, col_out});
		end
		$display("test register table done");
		// bypass: firmware drives columns and reads rows itself
		set_press(30'h4);
		wr_reg(8'hd1, 8'h1e);
		repeat (4) @(posedge clk);
		rd_chk("row bypass", 8'hd2, 8'h3b);
		wr_reg(8'hd1, 8'h0f);
		repeat (4) @(posedge clk);
		rd_chk("row bypass", 8'hd2, 8'h3f);
		$display("test bypass done");
		// single key at column 3, row 4, debounce 4 ticks, check 1 tick
		set_press(30'h1 << 22);
		wr_reg(8'hd4, 8'h05);
		for (i = 0; i < 1000 && key_irq !== 1'b1; i++) @(posedge clk);
		check("irq", 8'h01, {7'h0, key_irq});
		check("irq time", 8'h01, {7'h0, 1'(i >= 116 && i <= 170)});
		rd_chk("col code", 8'hd1, 8'h17);
		rd_chk("row code", 8'hd2, 8'h2f);
		set_press('0);
		wait_idle();
		rd_chk("status", 8'hd4, 8'h07);
		check("idle cols", 8'h00, {3'h0, col_out});
		$display("test single key done");
		// two keys on one row, gated for a while mid-scan
		wr_reg(8'hd4, 8'h07);
		set_press(30'h41);
		repeat (60) @(posedge clk);
		keypad_clock_enable <= 1'b0;
		repeat (20) @(posedge clk);
		keypad_clock_enable <= 1'b1;
		repeat (300) @(posedge clk);
		check("irq multi", 8'h00, {7'h0, key_irq});
		rd_chk("col kept", 8'hd1, 8'h17);
		set_press('0);
		wait_idle();
		$display("test multi key done");
		// scan enable cleared while a column is being driven
		set_press(30'h1 << 22);
		repeat (40) @(posedge clk);
		wr_reg(8'hd4, 8'h01);
		repeat (3) @(posedge clk);
		check("col stop", 8'h17, {3'h0, col_out});
		$display("test scan stop done");
		// reversed column order, longest debounce and check interval
		wr_reg(8'hd5, 8'h9c);
		wr_reg(8'hd6, 8'h02);
		wr_reg(8'hd3, 8'h00);
		wr_reg(8'hd4, 8'h05);
		repeat (2) @(posedge clk);
		for (i = 0; i < 2000 && col_out === 5'h00; i++) @(posedge clk);
		check("first col", 8'h0f, {3'h0, col_out});
		check("deb time", 8'h01, {7'h0, 1'(i >= 1010 && i <= 1040)});
		for (i = 0; i < 1000 && key_irq !== 1'b1; i++) @(posedge clk);
		check("scan time", 8'h01, {7'h0, 1'(i >= 470 && i <= 490)});
		rd_chk("order col code", 8'hd1, 8'h17);
		$display("test scan order done");
		// reset in mid-run with the key still held
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check("rst col", 8'h1f, {3'h0, col_out});
		check("rst irq", 8'h00, {7'h0, key_irq});
		rst <= 1'b0;
		rd_chk("rst status", 8'hd4, 8'h00);
		rd_chk("rst order", 8'hd5, 8'h88);
		repeat (40) @(posedge clk);
		check("rst scan off", 8'h1f, {3'h0, col_out});
		$display("test mid reset done");
		summarize();
	end
endmodule // kps_scanner_tb
